// >>> hw/apcsr_defs.svh
// Constants of the pin-configured converter readout block
`ifndef APCSR_DEFS_SVH
`define APCSR_DEFS_SVH

// Word and control codes
`define APCSR_WORD_W          24
`define APCSR_RATE_HS_A       3'h4
`define APCSR_RATE_HS_B       3'h5
`define APCSR_SCLK_SEL_INT    1'b0
`define APCSR_LVDS_N_LVDS     1'b0
`define APCSR_FULL_POS        24'h7FFFFF
`define APCSR_FULL_NEG        24'h800000
`define APCSR_WORD_RESET      24'h000000

// Conversion periods in master clocks, per rate code
`define APCSR_PER_R0          9'h100
`define APCSR_PER_R1          9'h080
`define APCSR_PER_R2          9'h040
`define APCSR_PER_R3          9'h020
`define APCSR_PER_R4          9'h010
`define APCSR_PER_R5          9'h008

// Results dropped after a start, per filter setting
`define APCSR_SETTLE_WB       3'h4
`define APCSR_SETTLE_LL_SINGLE 3'h1
`define APCSR_SETTLE_LL_FAST  3'h0

// Timing
`define APCSR_CLK_PERIOD_NS   50
`define APCSR_START_MIN_TCLK  2
`define APCSR_STROBE_LAG_TCLK 1
`define APCSR_HS_SCLK_PER_CLK 2'h3
`define APCSR_LS_SCLK_PER_CLK 2'h1
`define APCSR_SYNC_STAGES     2

`endif

// >>> hw/apcsr_pkg.sv
// Types of the pin-configured converter readout block
package apcsr_pkg;

  typedef enum logic [3:0]
  {
    ST_OFF    = 4'b0001,
    ST_IDLE   = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_RUN    = 4'b1000
  } apcsr_state_t;

  typedef logic [23:0] apcsr_word_t;

endpackage

// >>> hw/apcsr_word_if.sv
// Word hand-over from master clock domain to shift clock domain
`timescale 1ns/1ps
interface apcsr_word_if;
  logic                 toggle;
  apcsr_pkg::apcsr_word_t word;
  logic                 cs_n_pin;

  modport src
  (
    output toggle,
    output word,
    output cs_n_pin
  );

  modport snk
  (
    input toggle,
    input word,
    input cs_n_pin
  );
endinterface

// >>> hw/apcsr_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module apcsr_sync #(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // First stage feeds the second stage only
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;

endmodule

// >>> hw/apcsr_shifter.sv
// Serial data shifter running on the shift clock
`timescale 1ns/1ps
`include "apcsr_defs.svh"
module apcsr_shifter
(
  input  wire logic   shift_clk_i,
  input  wire logic   reset_n_i,
  apcsr_word_if.snk   wif,
  output logic        dout_p_o,
  output logic        dout_n_o
);
  import apcsr_pkg::*;

  logic        tog_s;
  logic        cs_n_s;
  logic        tog_seen_reg;
  apcsr_word_t sr_reg;
  logic [4:0]  bits_reg;
  logic        dout_p_reg;
  logic        dout_n_reg;
  logic        load;

  apcsr_sync #(.W(2)) u_sync
  (
    .clk_i     (shift_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({wif.toggle, wif.cs_n_pin}),
    .q_o       ({tog_s, cs_n_s})
  );

  // Word is held stable by the source for a whole conversion
  assign load = (tog_s != tog_seen_reg);

  always_ff @(posedge shift_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tog_seen_reg <= 1'b0;
    else
      tog_seen_reg <= tog_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge shift_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sr_reg     <= `APCSR_WORD_RESET;
      bits_reg   <= 5'h00;
      dout_p_reg <= 1'b0;
      dout_n_reg <= 1'b1;
    end
    else if (load)
    begin
      sr_reg   <= wif.word;
      bits_reg <= 5'(`APCSR_WORD_W);
    end
    else if (!cs_n_s && bits_reg != 5'h00)
    begin
      dout_p_reg <= sr_reg[23];
      dout_n_reg <= ~sr_reg[23];
      sr_reg     <= {sr_reg[22:0], 1'b0};
      bits_reg   <= bits_reg - 5'h01;
    end
  end

  assign dout_p_o = dout_p_reg;
  assign dout_n_o = dout_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_dout_pair_compl: assert property (@(posedge shift_clk_i) disable iff (!reset_n_i)
    dout_n_o == ~dout_p_o) else $error("data pair not complementary");

  a_load_full_word: assert property (@(posedge shift_clk_i) disable iff (!reset_n_i)
    load |=> bits_reg == 5'h18) else $error("load did not arm 24 bits");

  a_cs_holds_shift: assert property (@(posedge shift_clk_i) disable iff (!reset_n_i)
    (cs_n_s && !load) |=> $stable(bits_reg)) else $error("shifted while deselected");

  c_word_shifted: cover property (@(posedge shift_clk_i) disable iff (!reset_n_i)
    $fell(bits_reg != 5'h00));

endmodule

// >>> hw/apcsr_top.sv
// Pin configuration, conversion control and serial readout of the converter
`timescale 1ns/1ps
`include "apcsr_defs.svh"
module apcsr_top
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   shift_clk_i,
  input  wire logic                   start_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   power_down_n_i,
  input  wire logic [2:0]             rate_select_i,
  input  wire logic                   filter_path_sel_i,
  input  wire logic                   lowlat_settle_cfg_i,
  input  wire logic                   sclk_sel_i,
  input  wire logic                   lvds_n_i,
  input  wire apcsr_pkg::apcsr_word_t wb_data_i,
  input  wire apcsr_pkg::apcsr_word_t ll_data_i,
  input  wire logic                   modulator_overrange_i,
  output logic                        dout_p_o,
  output logic                        dout_n_o,
  output logic                        dout_oe_n_o,
  output logic                        data_ready_strobe_p_o,
  output logic                        data_ready_strobe_n_o,
  output logic                        sclk_p_o,
  output logic                        sclk_p_oe_n_o,
  output logic                        sclk_n_o,
  output logic                        sclk_n_oe_n_o,
  output logic [1:0]                  sclk_ratio_o,
  output logic                        lvds_mode_o,
  output logic                        high_speed_o,
  output logic                        filter_path_o,
  output logic                        lowlat_fast_o,
  output logic                        filter_reset_o,
  output logic                        filter_overrange_flag_o,
  output logic                        input_overrange_flag_o
);
  import apcsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_high_speed(input logic [2:0] r);
    is_high_speed = (r == `APCSR_RATE_HS_A) || (r == `APCSR_RATE_HS_B);
  endfunction

  function automatic logic [8:0] rate_period(input logic [2:0] r);
    case (r)
      3'h0:    rate_period = `APCSR_PER_R0;
      3'h1:    rate_period = `APCSR_PER_R1;
      3'h2:    rate_period = `APCSR_PER_R2;
      3'h3:    rate_period = `APCSR_PER_R3;
      3'h4:    rate_period = `APCSR_PER_R4;
      3'h5:    rate_period = `APCSR_PER_R5;
      default: rate_period = `APCSR_PER_R0;
    endcase
  endfunction

  function automatic logic [2:0] settle_need(input logic ll_path, input logic fast);
    if (!ll_path)
      settle_need = `APCSR_SETTLE_WB;
    else if (fast)
      settle_need = `APCSR_SETTLE_LL_FAST;
    else
      settle_need = `APCSR_SETTLE_LL_SINGLE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs
  logic       start_s;
  logic       cs_n_s;
  logic       pwr_up_s;
  logic [2:0] rate_s;
  logic       path_s;
  logic       llcfg_s;
  logic       sclk_sel_s;
  logic       lvds_n_s;

  apcsr_sync #(.W(10)) u_pin_sync
  (
    .clk_i     (sys_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({start_i, cs_n_i, power_down_n_i, rate_select_i, filter_path_sel_i,
                 lowlat_settle_cfg_i, sclk_sel_i, lvds_n_i}),
    .q_o       ({start_s, cs_n_s, pwr_up_s, rate_s, path_s, llcfg_s, sclk_sel_s, lvds_n_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  logic hs_reg;
  logic path_reg;
  logic llfast_reg;
  logic lvds_reg;
  logic ext_reg;
  logic ext_next;

  // External shift clock cannot be honoured in high-speed mode
  assign ext_next = (sclk_sel_s != `APCSR_SCLK_SEL_INT) && !is_high_speed(rate_s);

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hs_reg     <= 1'b0;
      path_reg   <= 1'b0;
      llfast_reg <= 1'b0;
      lvds_reg   <= 1'b0;
      ext_reg    <= 1'b0;
    end
    else
    begin
      hs_reg     <= is_high_speed(rate_s);
      path_reg   <= path_s;
      llfast_reg <= llcfg_s;
      lvds_reg   <= (lvds_n_s == `APCSR_LVDS_N_LVDS);
      ext_reg    <= ext_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start detection: needs two consecutive high samples
  logic [1:0] start_hi_reg;
  logic       start_evt;

  assign start_evt = start_s && (start_hi_reg == 2'(`APCSR_START_MIN_TCLK - 1)) && pwr_up_s;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      start_hi_reg <= 2'h0;
    else if (!start_s)
      start_hi_reg <= 2'h0;
    else if (start_hi_reg != 2'h3)
      start_hi_reg <= start_hi_reg + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  apcsr_state_t state_reg;
  logic [8:0]   per_cnt_reg;
  logic [2:0]   settle_cnt_reg;
  logic         conv_done;
  logic         launch;

  assign conv_done = (state_reg == ST_SETTLE || state_reg == ST_RUN) && (per_cnt_reg == 9'h000);
  assign launch    = conv_done && (state_reg == ST_RUN || settle_cnt_reg == 3'h0);

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_reg <= ST_OFF;
    else if (!pwr_up_s)
      state_reg <= ST_OFF;
    else if (start_evt)
      state_reg <= ST_SETTLE;
    else
    begin
      case (state_reg)
        ST_OFF:    state_reg <= ST_IDLE;
        ST_IDLE:   state_reg <= ST_IDLE;
        ST_SETTLE: if (launch) state_reg <= ST_RUN;
        ST_RUN:    state_reg <= ST_RUN;
        default:   state_reg <= ST_OFF;
      endcase
    end
  end

  // Restart on start keeps conversions aligned to the host
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      per_cnt_reg    <= 9'h000;
      settle_cnt_reg <= 3'h0;
    end
    else if (start_evt)
    begin
      per_cnt_reg    <= rate_period(rate_s) - 9'h001;
      settle_cnt_reg <= settle_need(path_s, llcfg_s);
    end
    else if (conv_done)
    begin
      per_cnt_reg <= rate_period(rate_s) - 9'h001;
      if (settle_cnt_reg != 3'h0)
        settle_cnt_reg <= settle_cnt_reg - 3'h1;
    end
    else if (per_cnt_reg != 9'h000)
      per_cnt_reg <= per_cnt_reg - 9'h001;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      filter_reset_o <= 1'b0;
    else
      filter_reset_o <= start_evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture, flags and strobe
  apcsr_word_t word_reg;
  logic        tog_reg;
  logic        strobe_reg;
  logic        fovr_reg;
  logic        iovr_reg;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      word_reg <= `APCSR_WORD_RESET;
      tog_reg  <= 1'b0;
      fovr_reg <= 1'b0;
    end
    else if (launch)
    begin
      word_reg <= path_reg ? ll_data_i : wb_data_i;
      tog_reg  <= ~tog_reg;
      fovr_reg <= (path_reg ? ll_data_i : wb_data_i) == `APCSR_FULL_POS ||
                  (path_reg ? ll_data_i : wb_data_i) == `APCSR_FULL_NEG;
    end
  end

  // Strobe lags the launch so the host's final edges fall well before it
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      strobe_reg <= 1'b0;
    else
      strobe_reg <= launch;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      iovr_reg <= 1'b0;
    else
      iovr_reg <= modulator_overrange_i && pwr_up_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  logic dout_oe_n_reg;
  logic sclkp_oe_n_reg;
  logic sclkn_oe_n_reg;
  logic [1:0] ratio_reg;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dout_oe_n_reg  <= 1'b1;
      sclkp_oe_n_reg <= 1'b1;
      sclkn_oe_n_reg <= 1'b1;
      ratio_reg      <= `APCSR_LS_SCLK_PER_CLK;
    end
    else
    begin
      dout_oe_n_reg  <= cs_n_s || !pwr_up_s;
      sclkp_oe_n_reg <= ext_next || !pwr_up_s;
      sclkn_oe_n_reg <= ext_next || !pwr_up_s;
      ratio_reg      <= is_high_speed(rate_s) ? `APCSR_HS_SCLK_PER_CLK : `APCSR_LS_SCLK_PER_CLK;
    end
  end

  apcsr_word_if wif ();

  assign wif.toggle   = tog_reg;
  assign wif.word     = word_reg;
  assign wif.cs_n_pin = cs_n_i;

  // External clock phases are the host's; shifter needs no minimum of its own
  apcsr_shifter u_shifter
  (
    .shift_clk_i (shift_clk_i),
    .reset_n_i   (reset_n_i),
    .wif         (wif),
    .dout_p_o    (dout_p_o),
    .dout_n_o    (dout_n_o)
  );

  assign dout_oe_n_o             = dout_oe_n_reg;
  assign data_ready_strobe_p_o   = strobe_reg;
  assign data_ready_strobe_n_o   = ~strobe_reg;
  assign sclk_p_o                = shift_clk_i;
  assign sclk_n_o                = ~shift_clk_i;
  assign sclk_p_oe_n_o           = sclkp_oe_n_reg;
  assign sclk_n_oe_n_o           = sclkn_oe_n_reg;
  assign sclk_ratio_o            = ratio_reg;
  assign lvds_mode_o             = lvds_reg;
  assign high_speed_o            = hs_reg;
  assign filter_path_o           = path_reg;
  assign lowlat_fast_o           = llfast_reg;
  assign filter_overrange_flag_o = fovr_reg;
  assign input_overrange_flag_o  = iovr_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_data_ready_strobe_one_clk: assert property ($rose(data_ready_strobe_p_o) |=> !data_ready_strobe_p_o)
    else $error("data ready wider than one clock");
  a_data_ready_strobe_after_launch: assert property ($rose(data_ready_strobe_p_o) |-> $past(launch))
    else $error("data ready without launch one clock before");
  a_dout_float_cs: assert property ($rose(cs_n_s) |=> dout_oe_n_o)
    else $error("data output driven after deselect");
  a_sclkn_float_ext: assert property (ext_next |=> sclk_n_oe_n_o && sclk_p_oe_n_o)
    else $error("shift clock pins driven with external clock");
  a_sclkp_drive_int: assert property ((!ext_next && pwr_up_s) |=> !sclk_p_oe_n_o)
    else $error("shift clock not driven with internal clock");
  a_hs_codes: assert property (##1 high_speed_o == ($past(rate_s) == 3'h4 || $past(rate_s) == 3'h5))
    else $error("speed mode decode wrong");
  a_start_resets: assert property (start_evt |=> filter_reset_o && state_reg == ST_SETTLE)
    else $error("start did not reset filter");
  a_start_two_high: assert property (start_evt |-> $past(start_s))
    else $error("start taken after one high sample");
  a_off_quiet: assert property (!pwr_up_s |=> state_reg == ST_OFF ##1 !data_ready_strobe_p_o)
    else $error("activity in power down");
  a_path_word: assert property ((launch && path_reg) |=> wif.word == $past(ll_data_i))
    else $error("low-latency word not captured");
  a_fovr_full: assert property ((launch && !path_reg && wb_data_i == 24'h7FFFFF) |=> filter_overrange_flag_o)
    else $error("overrange flag missed");
  a_strobe_pair: assert property (data_ready_strobe_n_o == ~data_ready_strobe_p_o)
    else $error("strobe pair not complementary");

  c_start_run: cover property (start_evt ##[1:300] state_reg == ST_RUN);
  c_two_strobes: cover property ($rose(data_ready_strobe_p_o) ##[1:300] $rose(data_ready_strobe_p_o));
  c_hs_mode: cover property (high_speed_o && data_ready_strobe_p_o);
  c_ovr: cover property (filter_overrange_flag_o && input_overrange_flag_o);

endmodule

// >>> tb/apcsr_host_model.sv
// Host model: drives start and chip select, shifts in result words
`timescale 1ns/1ps
module apcsr_host_model
(
  input  wire logic sys_clk_i,
  input  wire logic shift_clk_i,
  input  wire logic strobe_i,
  input  wire logic dout_p_i,
  output logic      start_o,
  output logic      cs_n_o
);
  import apcsr_pkg::*;
  logic [47:0] bits;
  initial
  begin
    start_o = 1'b0;
    cs_n_o  = 1'b1;
  end
  task automatic set_cs(input logic v);
    @(posedge sys_clk_i);
    #1 cs_n_o = v;
  endtask
  // Start held high two master clocks
  task automatic pulse_start();
    @(posedge sys_clk_i);
    #1 start_o = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 start_o = 1'b0;
  endtask
  // Whole word per strobe, slow rates only so the last edge leads the next strobe
  task automatic read_word(input apcsr_word_t exp, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    while (strobe_i !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    // Window wider than the word: load edge drifts with the crossing
    for (int i = 0; i < 48; i++)
    begin
      @(negedge shift_clk_i);
      bits[47-i] = dout_p_i;
    end
    for (int o = 0; o <= 24; o++)
      if (bits[47-o -: 24] === exp)
        ok = 1'b1;
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench of the converter readout block
`timescale 1ns/1ps
module tb_top;
  import apcsr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        shift_clk = 1'b0;
  logic        reset_n, pd_n, path_sel, llcfg, ssel, lvds_n, movr, ok;
  logic [2:0]  rate;
  apcsr_word_t lld, wbd;
  logic        start, cs_n, dp, dn, doe_n, stp, stn, spoe, snoe, sclk_p, sclk_n;
  logic [1:0]  ratio;
  logic        lvm_o, hs_o, path_o, fast_o, frst_o, fovr_o, iovr_o;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          n, k;
  int          t [3];
  int          per [8] = '{256, 128, 64, 32, 16, 8, 256, 256};
  apcsr_word_t ovr [3] = '{24'h7FFFFF, 24'h800000, 24'hA5C396};

  always #25 sys_clk = ~sys_clk;
  // 32 ns phases, above the host minimum
  always #32 shift_clk = ~shift_clk;

  apcsr_top dut
  (
    .sys_clk_i               (sys_clk),
    .reset_n_i               (reset_n),
    .shift_clk_i             (shift_clk),
    .start_i                 (start),
    .cs_n_i                  (cs_n),
    .power_down_n_i          (pd_n),
    .rate_select_i           (rate),
    .filter_path_sel_i       (path_sel),
    .lowlat_settle_cfg_i     (llcfg),
    .sclk_sel_i              (ssel),
    .lvds_n_i                (lvds_n),
    .wb_data_i               (wbd),
    .ll_data_i               (lld),
    .modulator_overrange_i   (movr),
    .dout_p_o                (dp),
    .dout_n_o                (dn),
    .dout_oe_n_o             (doe_n),
    .data_ready_strobe_p_o   (stp),
    .data_ready_strobe_n_o   (stn),
    .sclk_p_o                (sclk_p),
    .sclk_p_oe_n_o           (spoe),
    .sclk_n_o                (sclk_n),
    .sclk_n_oe_n_o           (snoe),
    .sclk_ratio_o            (ratio),
    .lvds_mode_o             (lvm_o),
    .high_speed_o            (hs_o),
    .filter_path_o           (path_o),
    .lowlat_fast_o           (fast_o),
    .filter_reset_o          (frst_o),
    .filter_overrange_flag_o (fovr_o),
    .input_overrange_flag_o  (iovr_o)
  );

  apcsr_host_model host
  (
    .sys_clk_i   (sys_clk),
    .shift_clk_i (shift_clk),
    .strobe_i    (stp),
    .dout_p_i    (doe_n ? ~dp : dp),    // Floating line has no pull, seen inverted
    .start_o     (start),
    .cs_n_o      (cs_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk1(input string w, input logic e, input logic g);
    chk(w, {23'h0, e}, {23'h0, g});
  endtask
  // Bounded wait, returns clocks until the next strobe
  task automatic wait_strobe(output int c);
    c = 0;
    do
    begin
      cyc(1);
      c++;
    end
    while (stp !== 1'b1 && c < 3000);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Run ceiling well above the roughly 8k clocks the tests take
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      miscompares++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    pd_n = 1'b1;
    rate = 3'h0;
    path_sel = 1'b1;
    llcfg = 1'b1;
    ssel = 1'b0;
    lvds_n = 1'b0;
    movr = 1'b0;
    lld = 24'hA5C396;
    wbd = 24'h5A3C69;
    cyc(12);
    chk1("strobe_n_rst", 1'b1, stn);
    chk1("dout_oe_rst", 1'b1, doe_n);
    reset_n = 1'b1;
    cyc(5);
    host.set_cs(1'b0);
    for (int c = 0; c < 8; c++)
    begin
      rate = c[2:0];
      cyc(4);
      chk1("high_speed", (c == 4 || c == 5), hs_o);
      chk("ratio", (c == 4 || c == 5) ? 24'h3 : 24'h1, {22'h0, ratio});
      host.pulse_start();
      wait_strobe(n);
      chk1("strobe_n", 1'b0, stn);
      wait_strobe(n);
      chk("period", 24'(per[c]), 24'(n));
      cyc(1);
      chk1("strobe_len", 1'b0, stp);
    end
    for (int s = 0; s < 3; s++)
    begin
      rate = 3'h5;
      path_sel = (s < 2);
      llcfg = (s == 0);
      lvds_n = s[0];
      pd_n = 1'b0;
      cyc(5);
      pd_n = 1'b1;
      cyc(5);
      chk1("path", path_sel, path_o);
      chk1("fast", llcfg, fast_o);
      chk1("lvds", ~lvds_n, lvm_o);
      host.pulse_start();
      k = 0;
      while (frst_o !== 1'b1 && k < 6)
      begin
        cyc(1);
        k++;
      end
      chk1("freset", 1'b1, frst_o);
      cyc(1);
      chk1("freset_end", 1'b0, frst_o);
      wait_strobe(t[s]);
    end
    chk("ll_single", 24'h8, 24'(t[1] - t[0]));
    chk("wide_band", 24'h20, 24'(t[2] - t[0]));
    // Wide-band path first, then the low-latency path
    for (int i = 0; i < 3; i++)
    begin
      path_sel = (i != 0);
      wbd = (i == 0) ? ovr[0] : 24'h5A3C69;
      lld = ovr[i];
      wait_strobe(n);
      wait_strobe(n);
      cyc(2);
      chk1("filt_ovr", (i < 2), fovr_o);
    end
    // Readout at the slowest rate, both filter paths
    rate = 3'h0;
    for (int p = 0; p < 2; p++)
    begin
      path_sel = p[0];
      host.pulse_start();
      host.read_word(p ? lld : wbd, ok);
      chk1("word", 1'b1, ok);
      chk1("dout_pair", ~dp, dn);
    end
    host.set_cs(1'b1);
    cyc(4);
    chk1("dout_float", 1'b1, doe_n);
    host.read_word(lld, ok);
    chk1("deselect_frozen", 1'b0, ok);
    host.set_cs(1'b0);
    cyc(4);
    chk1("dout_drive", 1'b0, doe_n);
    chk1("sclk_p_int", 1'b0, spoe);
    chk1("sclk_n_int", 1'b0, snoe);
    // Just after the shift clock falling edge so the pin copies have settled
    @(negedge shift_clk);
    #1;
    chk1("sclk_pair", ~sclk_p, sclk_n);
    chk1("sclk_p_copy", 1'b0, sclk_p);
    cyc(1);
    ssel = 1'b1;
    cyc(4);
    chk1("sclk_p_ext", 1'b1, spoe);
    chk1("sclk_n_ext", 1'b1, snoe);
    rate = 3'h4;
    cyc(4);
    chk1("sclk_hs", 1'b0, snoe);
    movr = 1'b1;
    cyc(3);
    chk1("in_ovr", 1'b1, iovr_o);
    pd_n = 1'b0;
    cyc(5);
    chk1("pd_ovr", 1'b0, iovr_o);
    chk1("pd_dout", 1'b1, doe_n);
    wait_strobe(n);
    chk("pd_strobes", 24'hBB8, 24'(n));
    final_report();
  end
endmodule
